// ### pkg/rset_pkg.sv
// constants and types shared by the rolling shutter exposure trigger
package rset_pkg;
    // ***********************
    // clock and timing
    // ***********************
    localparam int CLK_PERIOD_NS = 100;
    localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
    localparam int EXP_MAX_S = 30;
    localparam logic [31:0] MAX_EXP_CLK_DEF = 32'(longint'(EXP_MAX_S) * CLK_HZ);
    localparam logic [11:0] ROW_CLK_SMALL = 12'd2592;
    localparam logic [11:0] ROW_CLK_LARGE = 12'd2624;
    localparam logic [19:0] EXT_MIN_ROWS = 20'd3;
    // ***********************
    // register offsets
    // ***********************
    localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
    localparam logic [31:0] OFS_EXPOSE = 32'h0000_0004;
    localparam logic [31:0] OFS_CYCLE = 32'h0000_0008;
    localparam logic [31:0] OFS_WINDOW = 32'h0000_000c;
    localparam logic [31:0] OFS_SWTRIG = 32'h0000_0010;
    localparam logic [31:0] OFS_STATUS = 32'h0000_0014;
    localparam logic [31:0] OFS_MEASURE = 32'h0000_0018;
    // ***********************
    // fields and reset values
    // ***********************
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_LARGE_BIT = 1;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_MODE_MSB = 7;
    localparam int SWTRIG_BIT = 0;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] EXPOSE_RST = 32'h0000_0000;
    localparam logic [31:0] CYCLE_RST = 32'h0000_0000;
    localparam logic [11:0] WINDOW_RST = 12'h400;
    // ***********************
    // trigger modes
    // ***********************
    localparam logic [3:0] MD_INTERNAL = 4'h0;
    localparam logic [3:0] MD_INT_OVL = 4'h1;
    localparam logic [3:0] MD_EXTERNAL = 4'h2;
    localparam logic [3:0] MD_SOFTWARE = 4'h3;
    localparam logic [3:0] MD_EXT_EXP = 4'h4;
    localparam logic [3:0] MD_EXT_EXP_OVL = 4'h5;
    localparam logic [3:0] MD_EXT_START = 4'h6;
    localparam logic [3:0] MD_GC_INTERNAL = 4'h7;
    localparam logic [3:0] MD_GC_EXTERNAL = 4'h8;
    localparam logic [3:0] MD_GC_EXT_EXP = 4'h9;

    typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_EXPOSE, ST_READOUT, ST_GAP} rset_state_t;
endpackage

// ### pkg/rset_row_if.sv
// row timing signals between the sequencer and its row timer
`timescale 1ns/1ps
`default_nettype none
interface rset_row_if;
    logic restart;
    logic [11:0] rowLen;
    logic rowTick;
    modport ctrl(output restart, output rowLen, input rowTick);
    modport timer(input restart, input rowLen, output rowTick);
endinterface
`default_nettype wire

// ### hdl/rset_row_timer.sv
// row period timer: one tick per full row readout
`timescale 1ns/1ps
`default_nettype none
module rset_row_timer (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // row timing
    rset_row_if.timer row
);
    import rset_pkg::*;

    typedef struct packed {
        logic [11:0] cnt;
    } rset_tmr_state_t;

    rset_tmr_state_t s_q;
    rset_tmr_state_t s_d;

    // ***********************
    // counter
    // ***********************
    always_comb begin
        s_d = s_q;
        if (row.restart || row.rowTick) begin
            s_d.cnt = 12'h000;
        end else begin
            s_d.cnt = s_q.cnt + 12'h001;
        end
    end

    // restart wins over tick so rows align with the exposure start
    assign row.rowTick = !row.restart && (s_q.cnt == row.rowLen - 12'h001);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

// ### hdl/rset_trigger_top.sv
// exposure and readout sequencer for a rolling shutter sensor, with apb registers
//
// Notes on behaviour
// - while waiting for trigger in global clear modes, hold all rows draining.
// - ready output high whenever a trigger would be detected.
// - trigger rising edge drops the drain and starts exposure of all rows.
// - trigger falling edge ends row one exposure, starts rolling frame readout.
// - after full readout raise the drain and hold it until next trigger.
// - rows start together; each row ends one row after the previous one.
// - falling edge before frame readout time is ignored; a later one ends exposure.
// - exposing output high exactly for the row one exposure interval.
// - programmed exposure and cycle times round to the nearest whole row.
// - one row is 2592 clocks on small sensor, 2624 on large.
// - one frame is the row count of each half from readout_window.
// - plain external mode: programmed exposure, each trigger starts a cycle.
// - software mode: programmed exposure, each software trigger starts a cycle.
// - external overlap: exposure is rise to rise period, capped at 30 s.
// - internal and external start modes use programmed exposure and cycle.
// - global clear internal: short exposure cycles at readout time, long uses cycle.
// - short exposure is at most frame readout time, long is above it.
`timescale 1ns/1ps
`default_nettype none
module rset_trigger_top #(
    parameter logic [31:0] MAX_EXP_CLK = rset_pkg::MAX_EXP_CLK_DEF
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // trigger
    input wire logic external_trigger_in,
    // sensor side
    output logic trigReady,
    output logic pixelDrain,
    output logic exposingAll,
    output logic readoutActive,
    output logic rowStrobe,
    output logic frameDone
);
    import rset_pkg::*;

    typedef struct packed {
        rset_state_t st;
        logic trigMeta;
        logic trigSync;
        logic trigPrev;
        logic swPend;
        logic [31:0] ctrl;
        logic [31:0] expSet;
        logic [31:0] cycSet;
        logic [11:0] winRows;
        logic [31:0] expClk;
        logic [31:0] cycClk;
        logic [19:0] expRows;
        logic [19:0] measRows;
        logic rdBusy;
        logic [11:0] rdRow;
        logic rowStrobe;
        logic frameDone;
        logic drain;
        logic exposing;
        logic ready;
        logic [31:0] prdata;
    } rset_top_state_t;

    localparam rset_top_state_t RST_STATE = '{
        st: ST_IDLE,
        trigMeta: 1'b0,
        trigSync: 1'b0,
        trigPrev: 1'b0,
        swPend: 1'b0,
        ctrl: CTRL_RST,
        expSet: EXPOSE_RST,
        cycSet: CYCLE_RST,
        winRows: WINDOW_RST,
        expClk: 32'h0,
        cycClk: 32'h0,
        expRows: 20'h0,
        measRows: 20'h0,
        rdBusy: 1'b0,
        rdRow: 12'h0,
        rowStrobe: 1'b0,
        frameDone: 1'b0,
        drain: 1'b0,
        exposing: 1'b0,
        ready: 1'b0,
        prdata: 32'h0
    };

    rset_top_state_t s_q;
    rset_top_state_t s_d;
    rset_row_if rowBus ();

    logic [3:0] mode;
    logic enable;
    logic [11:0] halfRow;
    logic rise;
    logic fall;
    logic gcMode;
    logic ovlMode;
    logic extTrigMode;
    logic swTrigMode;
    logic freeRun;
    logic trigHit;
    logic expDue;
    logic cycDue;
    logic capDue;
    logic longExp;
    logic [23:0] frameClk;
    logic apbWr;
    logic apbSetup;
    logic mapped;

    // ***********************
    // row timer
    // ***********************
    assign rowBus.rowLen = s_q.ctrl[CTRL_LARGE_BIT] ? ROW_CLK_LARGE : ROW_CLK_SMALL;

    rset_row_timer rowTimer (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .row(rowBus.timer)
    );

    // ***********************
    // decode
    // ***********************
    assign mode = s_q.ctrl[CTRL_MODE_MSB:CTRL_MODE_LSB];
    assign enable = s_q.ctrl[CTRL_EN_BIT];
    assign halfRow = {1'b0, rowBus.rowLen[11:1]};
    // only the second and third sync stages are looked at
    assign rise = s_q.trigSync && !s_q.trigPrev;
    assign fall = !s_q.trigSync && s_q.trigPrev;
    assign gcMode = (mode == MD_GC_INTERNAL) || (mode == MD_GC_EXTERNAL)
        || (mode == MD_GC_EXT_EXP);
    assign ovlMode = (mode == MD_INT_OVL) || (mode == MD_EXT_EXP_OVL);
    assign extTrigMode = (mode == MD_EXTERNAL) || (mode == MD_EXT_EXP)
        || (mode == MD_EXT_EXP_OVL) || (mode == MD_EXT_START)
        || (mode == MD_GC_EXTERNAL) || (mode == MD_GC_EXT_EXP);
    assign swTrigMode = (mode == MD_SOFTWARE) || (mode == MD_GC_EXTERNAL);
    assign freeRun = (mode == MD_INTERNAL) || (mode == MD_INT_OVL)
        || (mode == MD_GC_INTERNAL);
    assign trigHit = (extTrigMode && rise) || (swTrigMode && s_q.swPend);
    // a row tick marks a whole row elapsed; rounding to nearest row adds half a row
    assign expDue = rowBus.rowTick && ({1'b0, s_q.expClk} + 33'(halfRow) + 33'h1
        >= {1'b0, s_q.expSet});
    assign cycDue = rowBus.rowTick && ({1'b0, s_q.cycClk} + 33'(halfRow) + 33'h1
        >= {1'b0, s_q.cycSet});
    assign capDue = (s_q.expClk + 32'h1 >= MAX_EXP_CLK);
    assign frameClk = 24'(s_q.winRows) * 24'(rowBus.rowLen);
    assign longExp = s_q.expSet > {8'h00, frameClk};
    assign apbWr = psel && penable && pwrite && mapped;
    assign apbSetup = psel && !penable;
    assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_EXPOSE) || (paddr == OFS_CYCLE)
        || (paddr == OFS_WINDOW) || (paddr == OFS_SWTRIG) || (paddr == OFS_STATUS)
        || (paddr == OFS_MEASURE);

    // ***********************
    // apb answers
    // ***********************
    // zero wait states: read data is prepared during the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = s_q.prdata;

    // ***********************
    // next state
    // ***********************
    always_comb begin
        s_d = s_q;
        rowBus.restart = 1'b0;
        // two flop synchroniser then an edge register
        s_d.trigMeta = external_trigger_in;
        s_d.trigSync = s_q.trigMeta;
        s_d.trigPrev = s_q.trigSync;
        s_d.rowStrobe = 1'b0;
        s_d.frameDone = 1'b0;

        // rolling readout runs beside the sequencer so overlap modes can expose meanwhile
        if (s_q.rdBusy && rowBus.rowTick) begin
            s_d.rowStrobe = 1'b1;
            if (s_q.rdRow + 12'h001 >= s_q.winRows) begin
                s_d.rdBusy = 1'b0;
                s_d.frameDone = 1'b1;
            end else begin
                s_d.rdRow = s_q.rdRow + 12'h001;
            end
        end

        if (s_q.st != ST_IDLE) begin
            s_d.cycClk = s_q.cycClk + 32'h1;
        end

        case (s_q.st)
            ST_IDLE: begin
                if (enable) begin
                    s_d.st = freeRun ? ST_EXPOSE : ST_WAIT;
                    if (freeRun) begin
                        rowBus.restart = 1'b1;
                        s_d.expClk = 32'h0;
                        s_d.expRows = 20'h0;
                        s_d.cycClk = 32'h0;
                    end
                end
            end
            ST_WAIT: begin
                if (trigHit) begin
                    s_d.swPend = 1'b0;
                    s_d.st = ST_EXPOSE;
                    rowBus.restart = 1'b1;
                    s_d.expClk = 32'h0;
                    s_d.expRows = 20'h0;
                    s_d.cycClk = 32'h0;
                end
            end
            ST_EXPOSE: begin
                s_d.expClk = s_q.expClk + 32'h1;
                if (rowBus.rowTick) begin
                    s_d.expRows = s_q.expRows + 20'h1;
                end
                if ((mode == MD_EXT_EXP_OVL && (rise || capDue))
                    || (mode == MD_EXT_EXP && fall && s_q.expRows >= EXT_MIN_ROWS)
                    || (mode == MD_GC_EXT_EXP && fall
                        && s_q.expRows >= 20'(s_q.winRows))
                    || (mode != MD_EXT_EXP_OVL && mode != MD_EXT_EXP
                        && mode != MD_GC_EXT_EXP && expDue)) begin
                    s_d.rdBusy = 1'b1;
                    s_d.rdRow = 12'h0;
                    s_d.measRows = s_d.expRows;
                    if (ovlMode) begin
                        // next exposure begins as the readout of this one starts
                        s_d.expClk = 32'h0;
                        s_d.expRows = 20'h0;
                        s_d.cycClk = 32'h0;
                    end else begin
                        s_d.st = ST_READOUT;
                    end
                end
            end
            ST_READOUT: begin
                if (!s_d.rdBusy) begin
                    if (mode == MD_GC_INTERNAL) begin
                        s_d.st = longExp ? ST_GAP : ST_EXPOSE;
                        if (!longExp) begin
                            rowBus.restart = 1'b1;
                            s_d.expClk = 32'h0;
                            s_d.expRows = 20'h0;
                            s_d.cycClk = 32'h0;
                        end
                    end else if (mode == MD_INTERNAL || mode == MD_EXT_START) begin
                        s_d.st = ST_GAP;
                    end else begin
                        s_d.st = ST_WAIT;
                    end
                end
            end
            ST_GAP: begin
                if (cycDue) begin
                    s_d.st = ST_EXPOSE;
                    rowBus.restart = 1'b1;
                    s_d.expClk = 32'h0;
                    s_d.expRows = 20'h0;
                    s_d.cycClk = 32'h0;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase

        if (!enable) begin
            s_d.st = ST_IDLE;
            s_d.rdBusy = 1'b0;
            // a pending software trigger dies with the enable, so a mode change made with the enable low cannot fire it
            s_d.swPend = 1'b0;
        end

        // register writes; a software trigger write wins over its own consumption
        if (apbWr) begin
            case (paddr)
                OFS_CTRL: s_d.ctrl = pwdata;
                OFS_EXPOSE: s_d.expSet = pwdata;
                OFS_CYCLE: s_d.cycSet = pwdata;
                OFS_WINDOW: s_d.winRows = pwdata[11:0];
                OFS_SWTRIG: begin
                    if (pwdata[SWTRIG_BIT]) begin
                        s_d.swPend = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        if (apbSetup) begin
            case (paddr)
                OFS_CTRL: s_d.prdata = s_q.ctrl;
                OFS_EXPOSE: s_d.prdata = s_q.expSet;
                OFS_CYCLE: s_d.prdata = s_q.cycSet;
                OFS_WINDOW: s_d.prdata = {20'h0, s_q.winRows};
                OFS_SWTRIG: s_d.prdata = {31'h0, s_q.swPend};
                OFS_STATUS: s_d.prdata = {24'h0, longExp, s_q.rdBusy, s_q.exposing,
                    s_q.drain, s_q.ready, s_q.st};
                OFS_MEASURE: s_d.prdata = {12'h0, s_q.measRows};
                default: s_d.prdata = 32'h0;
            endcase
        end

        // ***********************
        // sensor outputs, registered from next state
        // ***********************
        s_d.drain = gcMode && (s_d.st != ST_EXPOSE) && (s_d.st != ST_READOUT);
        s_d.exposing = (s_d.st == ST_EXPOSE);
        s_d.ready = (s_d.st == ST_WAIT)
            || (s_d.st == ST_EXPOSE && mode == MD_EXT_EXP_OVL);
    end

    // ***********************
    // state register
    // ***********************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    assign trigReady = s_q.ready;
    assign pixelDrain = s_q.drain;
    assign exposingAll = s_q.exposing;
    assign readoutActive = s_q.rdBusy;
    assign rowStrobe = s_q.rowStrobe;
    assign frameDone = s_q.frameDone;
endmodule
`default_nettype wire

// ### sim/rset_trigger_monitor.sv
// port checker for the rolling shutter trigger sequencer
`timescale 1ns/1ps
`default_nettype none
module rset_trigger_monitor #(
    parameter logic [31:0] MAX_EXP_CLK = rset_pkg::MAX_EXP_CLK_DEF
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // trigger and sensor
    input wire logic external_trigger_in,
    input wire logic trigReady,
    input wire logic pixelDrain,
    input wire logic exposingAll,
    input wire logic readoutActive,
    input wire logic rowStrobe,
    input wire logic frameDone
);
    import rset_pkg::*;
    // ****
    // helper state
    // ****
    typedef struct packed {
        logic gc, big, tPrev, seen;
        logic [11:0] win;
        logic [31:0] expCnt, tCnt, tLen, gap, nStr;
    } rset_mon_t;
    rset_mon_t s_q, s_d;
    logic wr;
    logic [31:0] rowLen, frameClk;
    assign wr = psel && penable && pwrite;
    assign rowLen = s_q.big ? 32'(ROW_CLK_LARGE) : 32'(ROW_CLK_SMALL);
    assign frameClk = 32'(s_q.win) * rowLen;
    // trigger width restarts only on an accepted rise, so an ignored fall keeps counting
    always_comb begin
        s_d = s_q;
        if (wr && paddr == OFS_CTRL) begin
            s_d.gc = pwdata[CTRL_EN_BIT] && pwdata[CTRL_MODE_MSB:CTRL_MODE_LSB] == MD_GC_EXT_EXP;
            s_d.big = pwdata[CTRL_LARGE_BIT];
        end
        if (wr && paddr == OFS_WINDOW) s_d.win = pwdata[11:0];
        s_d.tPrev = external_trigger_in;
        s_d.tCnt = (external_trigger_in && !s_q.tPrev && trigReady) ? 32'h1 : s_q.tCnt + 32'h1;
        if (!external_trigger_in && s_q.tPrev) s_d.tLen = s_q.tCnt;
        s_d.expCnt = exposingAll ? s_q.expCnt + 32'h1 : 32'h0;
        s_d.gap = rowStrobe ? 32'h0 : s_q.gap + 32'h1;
        s_d.seen = readoutActive && (s_q.seen || rowStrobe);
        s_d.nStr = readoutActive ? s_q.nStr + 32'(rowStrobe) : 32'h0;
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.win <= WINDOW_RST;
        end else begin
            s_q <= s_d;
        end
    end
    // ****
    // assertions
    // ****
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_clear_wait: assert property (s_q.gc && trigReady |-> pixelDrain)
        else $error("drain low while armed");
    a_rise_expose: assert property (s_q.gc && trigReady && $rose(external_trigger_in) |->
        ##[3:5] (exposingAll && !pixelDrain)) else $error("rise did not start exposure");
    a_expose_excl: assert property (s_q.gc && exposingAll |-> !pixelDrain && !trigReady)
        else $error("drain or ready during exposure");
    a_end_readout: assert property (s_q.gc && $fell(exposingAll) |-> readoutActive)
        else $error("exposure end without readout");
    a_early_fall: assert property (s_q.gc && exposingAll && $fell(external_trigger_in) &&
        s_q.expCnt + 32'd8 < frameClk |=> exposingAll [*6]) else $error("early fall honoured");
    a_frame_done: assert property (s_q.gc && $fell(readoutActive) |->
        frameDone && pixelDrain && trigReady) else $error("frame end without clear");
    a_drain_hold: assert property (s_q.gc && $fell(pixelDrain) |-> exposingAll)
        else $error("drain dropped without trigger");
    a_row_spacing: assert property (rowStrobe && s_q.seen |-> s_q.gap == rowLen - 32'h1)
        else $error("row strobe spacing wrong");
    a_strobe_count: assert property (s_q.gc && frameDone |->
        s_q.nStr + 32'(rowStrobe) == 32'(s_q.win)) else $error("row count per frame wrong");
    a_expose_width: assert property (s_q.gc && $fell(exposingAll) |->
        s_q.expCnt + 32'h1 >= s_q.tLen && s_q.expCnt <= s_q.tLen + 32'h1)
        else $error("exposure width differs from trigger width");
endmodule
bind rset_trigger_top rset_trigger_monitor #(.MAX_EXP_CLK(MAX_EXP_CLK)) u_mon (
    .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_trigger_in(external_trigger_in), .trigReady(trigReady), .pixelDrain(pixelDrain),
    .exposingAll(exposingAll), .readoutActive(readoutActive), .rowStrobe(rowStrobe),
    .frameDone(frameDone)
);
`default_nettype wire

// ### sim/rset_trig_source.sv
// model of the external trigger source driving the trigger pin
`timescale 1ns/1ps
`default_nettype none
module rset_trig_source (
    // clock
    input wire logic clk_sys,
    // trigger pin
    output logic trigOut
);
    initial trigOut = 1'b0;
    // a nonzero dipAt adds a short low dip inside the pulse, which the device must ignore
    task automatic pulse(input int hiClk, input int dipAt, input int gapClk);
        trigOut <= 1'b1;
        if (dipAt > 0) begin
            repeat (dipAt) @(posedge clk_sys);
            trigOut <= 1'b0;
            repeat (50) @(posedge clk_sys);
            trigOut <= 1'b1;
            repeat (hiClk - dipAt - 50) @(posedge clk_sys);
        end else begin
            repeat (hiClk) @(posedge clk_sys);
        end
        trigOut <= 1'b0;
        repeat (gapClk) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the rolling shutter trigger sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
    import rset_pkg::*;
    logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, err;
    logic trigReady, pixelDrain, exposingAll, readoutActive, rowStrobe, frameDone;
    logic [31:0] paddr, pwdata, prdata, rd;
    wire trigPin;
    int n_mismatch = 0;
    int n_checks = 0;
    // short overlap cap keeps any long count inside the run
    rset_trigger_top #(.MAX_EXP_CLK(32'd20000)) u_dut (
        .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_trigger_in(trigPin), .trigReady(trigReady), .pixelDrain(pixelDrain),
        .exposingAll(exposingAll), .readoutActive(readoutActive), .rowStrobe(rowStrobe),
        .frameDone(frameDone)
    );
    rset_trig_source u_src (.clk_sys(clk_sys), .trigOut(trigPin));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // ****
    // shared tasks
    // ****
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic run_frame(input int hi, input int dip, input int win, input int rl, input int rows);
        int n, t, t0, t1, s;
        fork
            u_src.pulse(hi, dip, (win + 5) * rl);
            begin
                n = 0;
                while (exposingAll !== 1'b1 && n < 20) begin
                    @(posedge clk_sys);
                    n++;
                end
                `CHK(n inside {[3:6]}, 1'b1)
                `CHK({pixelDrain, trigReady}, 2'b00)
                n = 0;
                while (exposingAll === 1'b1 && n < 40000) begin
                    @(posedge clk_sys);
                    n++;
                end
                `CHK(n >= hi - 1 && n <= hi + 1, 1'b1)
                `CHK(readoutActive, 1'b1)
                t = 0;
                s = 0;
                t0 = 0;
                t1 = 0;
                while (frameDone !== 1'b1 && t < 40000) begin
                    @(posedge clk_sys);
                    t++;
                    if (rowStrobe === 1'b1) begin
                        s++;
                        if (s == 1) t0 = t;
                        t1 = t;
                    end
                end
                `CHK(s, win)
                `CHK(t1 - t0, (win - 1) * rl)
                `CHK({pixelDrain, trigReady, readoutActive}, 3'b110)
            end
        join
        `CHK(pixelDrain, 1'b1)
        apb(OFS_MEASURE, 1'b0, 32'h0);
        `CHK(rd, 32'(rows))
    endtask
    // ****
    // scenarios
    // ****
    task automatic s_reset();
        `CHK({trigReady, pixelDrain, exposingAll, readoutActive}, 4'h0)
        apb(OFS_WINDOW, 1'b0, 32'h0);
        `CHK(rd[11:0], WINDOW_RST)
        apb(OFS_EXPOSE, 1'b0, 32'h0);
        `CHK(rd, EXPOSE_RST)
        apb(32'h0000_0040, 1'b0, 32'h0);
        `CHK({err, rd}, 33'h1_0000_0000)
    endtask
    task automatic s_arm(input logic [31:0] win, input logic big);
        apb(OFS_CTRL, 1'b1, 32'h0);
        apb(OFS_WINDOW, 1'b1, win);
        apb(OFS_CTRL, 1'b1, (32'(MD_GC_EXT_EXP) << CTRL_MODE_LSB) | (32'(big) << 1) | 32'h1);
        repeat (2) @(posedge clk_sys);
        `CHK({pixelDrain, trigReady}, 2'b11)
        apb(OFS_STATUS, 1'b0, 32'h0);
        `CHK(rd[4:0], 5'h19)
    endtask
    // plain pulse of three rows on a two-row window
    task automatic s_plain();
        run_frame(3 * 2592, 0, 2, 2592, 3);
    endtask
    // early fall after one row must be skipped; the later fall ends exposure
    task automatic s_early();
        run_frame(3 * 2592, 2592, 2, 2592, 3);
    endtask
    // larger sensor row on a three-row window
    task automatic s_large();
        run_frame(4 * 2624, 0, 3, 2624, 4);
    endtask
    // software trigger, programmed exposure of 1.93 rows must round up to two rows
    task automatic s_soft();
        int n;
        apb(OFS_CTRL, 1'b1, 32'h0);
        apb(OFS_WINDOW, 1'b1, 32'h2);
        apb(OFS_EXPOSE, 1'b1, 32'h0000_1388);
        apb(OFS_CTRL, 1'b1, (32'(MD_SOFTWARE) << CTRL_MODE_LSB) | 32'h1);
        apb(OFS_SWTRIG, 1'b0, 32'h0);
        `CHK({trigReady, pixelDrain, rd[0]}, 3'b100)
        apb(OFS_SWTRIG, 1'b1, 32'h1);
        @(posedge clk_sys);
        `CHK(exposingAll, 1'b1)
        n = 0;
        while (exposingAll === 1'b1 && n < 40000) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK(n, 2 * 32'(ROW_CLK_SMALL))
        while (frameDone !== 1'b1 && n < 60000) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK({trigReady, pixelDrain, readoutActive}, 3'b100)
        apb(OFS_MEASURE, 1'b0, 32'h0);
        `CHK(rd, 32'h2)
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_mismatch++;
        finish_test();
    end
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        s_reset();
        s_arm(32'h2, 1'b0);
        s_plain();
        s_early();
        s_arm(32'h3, 1'b1);
        s_large();
        s_soft();
        finish_test();
    end
endmodule
`default_nettype wire
